/* design/efmc_pkg.sv */
// package: register map, field layout and carriers of the freeze/marker capture
package efmc_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL      = 8'h00;
    localparam logic [7:0] OFF_FLAGS     = 8'h04;
    localparam logic [7:0] OFF_INT_STAT  = 8'h08;
    localparam logic [7:0] OFF_INT_MASK  = 8'h0C;
    localparam logic [7:0] OFF_REF_FTRN  = 8'h10;
    localparam logic [7:0] OFF_REF_FPOS  = 8'h14;
    localparam logic [7:0] OFF_FBK_FTRN  = 8'h18;
    localparam logic [7:0] OFF_FBK_FPOS  = 8'h1C;
    localparam logic [7:0] OFF_REF_MPOS  = 8'h20;
    localparam logic [7:0] OFF_REF_MTRN  = 8'h24;
    localparam logic [7:0] OFF_FBK_MPOS  = 8'h28;
    localparam logic [7:0] OFF_FBK_MTRN  = 8'h2C;
    // control field positions
    localparam int CTRL_FRZ_EN     = 0;
    localparam int CTRL_EDGE_FALL  = 1;
    // flag and interrupt bit positions (same layout)
    localparam int FLG_REF_FRZ     = 0;
    localparam int FLG_FBK_FRZ     = 1;
    localparam int FLG_REF_MRK     = 2;
    localparam int FLG_FBK_MRK     = 3;
    localparam int NUM_FLAGS       = 4;
    // encoder index
    localparam int ENC_REF         = 0;
    localparam int ENC_FBK         = 1;
    localparam int NUM_ENC         = 2;
    // reset values
    localparam logic [1:0]  CTRL_RST  = 2'h0;
    localparam logic [3:0]  FLAGS_RST = 4'h0;
    localparam logic [3:0]  MASK_RST  = 4'h0;
    localparam logic [31:0] SNAP_RST  = 32'h0000_0000;
    // encoder counter sample seen from the counters
    typedef struct packed {
        logic        marker;
        logic [31:0] turns;
        logic [31:0] position;
    } efmc_enc_t;
    // captured snapshot
    typedef struct packed {
        logic [31:0] turns;
        logic [31:0] position;
    } efmc_snap_t;
    // bus transfer states
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b01,
        ST_ACCESS = 2'b10
    } efmc_bus_st_t;
endpackage

/* design/efmc_edge_sync.sv */
// freeze input synchroniser with rising and falling edge detection
`timescale 1ns/1ps
module efmc_edge_sync (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // asynchronous level in
    input  wire logic din,
    // one-cycle edge pulses out
    output logic      rise,
    output logic      fall
);
    logic meta_reg;    // first stage, read only by the second
    logic sync_reg;    // second stage, safe to use
    logic last_reg;    // previous synchronised level
    logic [2:0] fill_reg;    // marks stages that hold a real pin sample

    ////////////////////////////////////////////////////////////////////////
    // two-flop synchroniser then a history flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
            fill_reg <= 3'h0;
        end else begin
            meta_reg <= din;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
            fill_reg <= {fill_reg[1:0], 1'b1};
        end
    end

    // edges taken from the safe stages only, once every stage has been filled,
    // so a pin that stands high across reset release is not seen as an edge
    assign rise = fill_reg[2] & sync_reg & ~last_reg;
    assign fall = fill_reg[2] & ~sync_reg & last_reg;
endmodule

/* design/efmc_capture.sv */
// freeze and marker position capture with apb registers and interrupt
`timescale 1ns/1ps
module efmc_capture (
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic [31:0]            prdata,
    // encoder counters
    input  wire efmc_pkg::efmc_enc_t ref_enc,
    input  wire efmc_pkg::efmc_enc_t fbk_enc,
    // freeze pin, asynchronous
    input  wire logic              freeze_trigger_input,
    // interrupt, level
    output logic                   irq
);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    // software control
    logic [1:0]                 ctrl_reg;       // enable and edge select
    logic [1:0]                 ctrl_next;
    // capture flags
    logic [3:0]                 flags_reg;      // freeze and marker flags
    logic [3:0]                 flags_next;
    // interrupt status and mask
    logic [3:0]                 int_stat_reg;   // sticky events
    logic [3:0]                 int_stat_next;
    logic [3:0]                 int_mask_reg;   // one enables the event
    logic [3:0]                 int_mask_next;
    // snapshots per encoder
    efmc_pkg::efmc_snap_t       frz_reg [efmc_pkg::NUM_ENC];
    efmc_pkg::efmc_snap_t       mrk_reg [efmc_pkg::NUM_ENC];
    // read data
    logic [31:0]                prdata_reg;
    logic [31:0]                prdata_next;
    logic                       pslverr_reg;
    logic                       pslverr_next;
    // bus state
    efmc_pkg::efmc_bus_st_t     bus_st_reg;
    efmc_pkg::efmc_bus_st_t     bus_st_next;

    // encoder array view
    efmc_pkg::efmc_enc_t        enc [efmc_pkg::NUM_ENC];
    // freeze edges
    wire logic                  frz_rise;
    wire logic                  frz_fall;
    wire logic                  frz_edge;
    // per encoder events
    logic [1:0]                 frz_take;
    logic [1:0]                 mrk_take;
    // all events in flag layout
    wire logic [3:0]            events;

    // bus decode
    wire logic                  setup_ph;
    wire logic                  wr_en;
    wire logic                  rd_en;
    wire logic                  hit_ctrl;
    wire logic                  hit_flags;
    wire logic                  hit_stat;
    wire logic                  hit_mask;
    wire logic                  hit_snap;
    wire logic                  mapped;
    wire logic [3:0]            flags_keep;
    wire logic [3:0]            stat_keep;
    logic [31:0]                rd_mux;

    ////////////////////////////////////////////////////////////////////////
    // freeze pin conditioning

    // synchronise and detect both edges
    efmc_edge_sync u_frz_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (freeze_trigger_input),
        .rise    (frz_rise),
        .fall    (frz_fall)
    );

    // pick the edge that triggers a snapshot
    assign frz_edge = ctrl_reg[efmc_pkg::CTRL_EDGE_FALL] ? frz_fall : frz_rise;

    // map the two counters onto the array
    assign enc[efmc_pkg::ENC_REF] = ref_enc;
    assign enc[efmc_pkg::ENC_FBK] = fbk_enc;

    ////////////////////////////////////////////////////////////////////////
    // per encoder capture

    generate
        for (genvar g = 0; g < efmc_pkg::NUM_ENC; g++) begin : g_enc
            // freeze flag of this encoder
            wire logic frz_flag;
            assign frz_flag = flags_reg[efmc_pkg::FLG_REF_FRZ + g];

            // one pin snapshots both encoders
            // only when enabled and flag clear
            assign frz_take[g] = frz_edge & ctrl_reg[efmc_pkg::CTRL_FRZ_EN] & ~frz_flag;

            // marker always captures, overwriting old data
            assign mrk_take[g] = enc[g].marker;

            // freeze snapshot storage
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    frz_reg[g] <= {efmc_pkg::SNAP_RST, efmc_pkg::SNAP_RST};
                end else if (frz_take[g]) begin
                    frz_reg[g] <= {enc[g].turns, enc[g].position};
                end
            end

            // marker snapshot storage
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    mrk_reg[g] <= {efmc_pkg::SNAP_RST, efmc_pkg::SNAP_RST};
                end else if (mrk_take[g]) begin
                    mrk_reg[g] <= {enc[g].turns, enc[g].position};
                end
            end
        end
    endgenerate

    // events in flag layout; freeze flags rise with the write
    assign events = {mrk_take[efmc_pkg::ENC_FBK], mrk_take[efmc_pkg::ENC_REF],
                     frz_take[efmc_pkg::ENC_FBK], frz_take[efmc_pkg::ENC_REF]};

    ////////////////////////////////////////////////////////////////////////
    // apb decode

    // write takes effect in the access phase, read data is latched in the setup phase
    assign setup_ph  = psel & ~penable;
    assign wr_en     = psel & penable & pwrite;
    assign rd_en     = setup_ph & ~pwrite;

    // address hits, word aligned only
    assign hit_ctrl  = (paddr == efmc_pkg::OFF_CTRL);
    assign hit_flags = (paddr == efmc_pkg::OFF_FLAGS);
    assign hit_stat  = (paddr == efmc_pkg::OFF_INT_STAT);
    assign hit_mask  = (paddr == efmc_pkg::OFF_INT_MASK);
    assign hit_snap  = (paddr[1:0] == 2'h0) &
                       (paddr >= efmc_pkg::OFF_REF_FTRN) &
                       (paddr <= efmc_pkg::OFF_FBK_MTRN);
    assign mapped    = hit_ctrl | hit_flags | hit_stat | hit_mask | hit_snap;

    // flags clear where software writes zero
    assign flags_keep = (wr_en & hit_flags) ? pwdata[3:0] : 4'hF;
    // status clears where software writes one
    assign stat_keep  = (wr_en & hit_stat) ? ~pwdata[3:0] : 4'hF;

    // read multiplexer
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            efmc_pkg::OFF_CTRL:     rd_mux = {30'h0, ctrl_reg};
            efmc_pkg::OFF_FLAGS:    rd_mux = {28'h0, flags_reg};
            efmc_pkg::OFF_INT_STAT: rd_mux = {28'h0, int_stat_reg};
            efmc_pkg::OFF_INT_MASK: rd_mux = {28'h0, int_mask_reg};
            // freeze: turns then position per encoder
            efmc_pkg::OFF_REF_FTRN: rd_mux = frz_reg[efmc_pkg::ENC_REF].turns;
            efmc_pkg::OFF_REF_FPOS: rd_mux = frz_reg[efmc_pkg::ENC_REF].position;
            efmc_pkg::OFF_FBK_FTRN: rd_mux = frz_reg[efmc_pkg::ENC_FBK].turns;
            efmc_pkg::OFF_FBK_FPOS: rd_mux = frz_reg[efmc_pkg::ENC_FBK].position;
            // marker: position then turns per encoder
            efmc_pkg::OFF_REF_MPOS: rd_mux = mrk_reg[efmc_pkg::ENC_REF].position;
            efmc_pkg::OFF_REF_MTRN: rd_mux = mrk_reg[efmc_pkg::ENC_REF].turns;
            efmc_pkg::OFF_FBK_MPOS: rd_mux = mrk_reg[efmc_pkg::ENC_FBK].position;
            efmc_pkg::OFF_FBK_MTRN: rd_mux = mrk_reg[efmc_pkg::ENC_FBK].turns;
            // unmapped reads as zero
            default:                rd_mux = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // next state of the register file

    always_comb begin
        // hold by default
        ctrl_next     = ctrl_reg;
        int_mask_next = int_mask_reg;
        prdata_next   = prdata_reg;
        pslverr_next  = pslverr_reg;
        bus_st_next   = bus_st_reg;
        // control write
        if (wr_en & hit_ctrl) begin
            ctrl_next = pwdata[1:0];
        end
        // mask write
        if (wr_en & hit_mask) begin
            int_mask_next = pwdata[3:0];
        end
        // a new event wins over a clear in the same cycle
        flags_next    = events | (flags_reg & flags_keep);
        int_stat_next = events | (int_stat_reg & stat_keep);
        // bus sequencer: data and error latched in setup
        case (bus_st_reg)
            efmc_pkg::ST_IDLE: begin
                if (setup_ph) begin
                    bus_st_next  = efmc_pkg::ST_ACCESS;
                    pslverr_next = ~mapped;
                    prdata_next  = rd_en ? rd_mux : 32'h0000_0000;
                end
            end
            efmc_pkg::ST_ACCESS: begin
                // access always completes in one cycle
                bus_st_next  = efmc_pkg::ST_IDLE;
                if (setup_ph) begin
                    // back to back setup right after access
                    bus_st_next  = efmc_pkg::ST_ACCESS;
                    pslverr_next = ~mapped;
                    prdata_next  = rd_en ? rd_mux : 32'h0000_0000;
                end
            end
            default: begin
                bus_st_next = efmc_pkg::ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // control and mask registers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg     <= efmc_pkg::CTRL_RST;
            int_mask_reg <= efmc_pkg::MASK_RST;
        end else begin
            ctrl_reg     <= ctrl_next;
            int_mask_reg <= int_mask_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // capture flags and interrupt status

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_reg    <= efmc_pkg::FLAGS_RST;
            int_stat_reg <= efmc_pkg::FLAGS_RST;
        end else begin
            flags_reg    <= flags_next;
            int_stat_reg <= int_stat_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus answer registers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
            bus_st_reg  <= efmc_pkg::ST_IDLE;
        end else begin
            prdata_reg  <= prdata_next;
            pslverr_reg <= pslverr_next;
            bus_st_reg  <= bus_st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    // zero wait states
    assign pready  = 1'b1;
    // error only shown in the access phase
    assign pslverr = pslverr_reg & psel & penable;
    // read data from the flop
    assign prdata  = prdata_reg;
    // level interrupt from unmasked sticky status
    assign irq     = |(int_stat_reg & int_mask_reg);

endmodule

/* verif/efmc_capture_checker.sv */
// assertion checker for the freeze/marker capture block, bound to its ports
`timescale 1ns/1ps
module efmc_capture_checker (
    // clock and reset
    input wire logic                pclk,
    input wire logic                presetn,
    // apb slave side
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [7:0]          paddr,
    input wire logic                pready,
    input wire logic                pslverr,
    input wire logic [31:0]         prdata,
    // encoder counters and pin
    input wire efmc_pkg::efmc_enc_t ref_enc,
    input wire efmc_pkg::efmc_enc_t fbk_enc,
    input wire logic                freeze_trigger_input,
    // interrupt
    input wire logic                irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////
    wire logic  acc;    // access phase of a transfer
    wire logic  bad;    // address outside the map or unaligned
    wire logic  rd_acc; // read access phase
    logic [31:0] rmp_q, rmp_d, fmt_q, fmt_d; // marker data and its one-edge delay
    assign acc = psel && penable;
    assign rd_acc = acc && !pwrite;
    assign bad = (paddr > efmc_pkg::OFF_FBK_MTRN) || (paddr[1:0] != 2'h0);
    // shadow of marker captures; read data is taken one edge before the access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rmp_q <= 32'h0;
            fmt_q <= 32'h0;
            rmp_d <= 32'h0;
            fmt_d <= 32'h0;
        end else begin
            rmp_q <= ref_enc.marker ? ref_enc.position : rmp_q;
            fmt_q <= fbk_enc.marker ? fbk_enc.turns : fmt_q;
            rmp_d <= rmp_q;
            fmt_d <= fmt_q;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    a_no_wait: assert property (acc |-> pready) else $error("wait state inserted");
    a_err_decode: assert property (acc |-> pslverr == bad) else $error("slave error decode wrong");
    a_bad_rd_zero: assert property (rd_acc && bad |-> prdata == 32'h0) else $error("unmapped read not zero");
    a_rdata_hold: assert property (!(psel && !penable) |=> $stable(prdata)) else $error("read data moved");
    a_ref_mpos: assert property (rd_acc && paddr == efmc_pkg::OFF_REF_MPOS |-> prdata == rmp_d)
        else $error("reference marker position wrong");
    a_fbk_mtrn: assert property (rd_acc && paddr == efmc_pkg::OFF_FBK_MTRN |-> prdata == fmt_d)
        else $error("feedback marker turns wrong");
    a_ref_mflag: assert property (rd_acc && paddr == efmc_pkg::OFF_FLAGS && $past(ref_enc.marker, 2)
        && $past(presetn) |-> prdata[efmc_pkg::FLG_REF_MRK]) else $error("reference marker flag not set");
    a_fbk_mflag: assert property (rd_acc && paddr == efmc_pkg::OFF_FLAGS && $past(fbk_enc.marker, 2)
        && $past(presetn) |-> prdata[efmc_pkg::FLG_FBK_MRK]) else $error("feedback marker flag not set");
    a_irq_fall: assert property ($fell(irq) |-> $past(acc && pwrite && (paddr == efmc_pkg::OFF_INT_STAT
        || paddr == efmc_pkg::OFF_INT_MASK))) else $error("interrupt dropped without a write");
    a_irq_cause: assert property ($rose(irq) |-> $past(ref_enc.marker || fbk_enc.marker || acc && pwrite
        && paddr == efmc_pkg::OFF_INT_MASK) || $past(freeze_trigger_input, 3) != $past(freeze_trigger_input, 4))
        else $error("interrupt raised without a cause");
endmodule
bind efmc_capture efmc_capture_checker u_efmc_capture_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .ref_enc(ref_enc), .fbk_enc(fbk_enc), .freeze_trigger_input(freeze_trigger_input), .irq(irq));

/* verif/efmc_enc_model.sv */
// encoder counters and freeze pin standing at the far side of the capture block
`timescale 1ns/1ps
module efmc_enc_model (
    // clock and reset
    input  wire logic           pclk,
    input  wire logic           presetn,
    // commands from the bench
    input  wire logic [1:0]     mrk_cmd,
    input  wire logic           frz_cmd,
    // counters and pin toward the block
    output efmc_pkg::efmc_enc_t ref_enc,
    output efmc_pkg::efmc_enc_t fbk_enc,
    output logic                frz_pin
);
    logic [31:0] cnt_reg; // moves every cycle so each capture edge sees new data
    // free-running count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 32'h0000_0100;
        end else begin
            cnt_reg <= cnt_reg + 32'h0000_0007;
        end
    end
    // reference and feedback differ so a swapped capture shows up
    assign ref_enc = '{mrk_cmd[0], cnt_reg >> 4, cnt_reg};
    assign fbk_enc = '{mrk_cmd[1], cnt_reg << 3, ~cnt_reg};
    assign frz_pin = frz_cmd;
endmodule

/* verif/efmc_capture_tb_top.sv */
// self-checking bench for the freeze/marker capture block
`timescale 1ns/1ps
module efmc_capture_tb_top;
    logic                pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, frz_cmd, frz_pin, er;
    logic [7:0]          paddr;
    logic [31:0]         pwdata, prdata, rd, mp, mt;
    logic [1:0]          mrk_cmd;
    logic [31:0]         ft[2], fp[2]; // expected freeze snapshots
    efmc_pkg::efmc_enc_t ref_enc, fbk_enc;
    int                  n_fail, n_compared;
    ////////////////////////////////////////////////////////////////////////
    efmc_capture u_efmc_capture (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .ref_enc(ref_enc), .fbk_enc(fbk_enc), .freeze_trigger_input(frz_pin), .irq(irq));
    efmc_enc_model u_efmc_enc_model (.pclk(pclk), .presetn(presetn), .mrk_cmd(mrk_cmd), .frz_cmd(frz_cmd),
        .ref_enc(ref_enc), .fbk_enc(fbk_enc), .frz_pin(frz_pin));
    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 50);
        if (pready !== 1'b1) begin
            n_fail++;
            print_verdict();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    // move the pin; capture lands two edges after the first synchroniser sample
    task automatic frz(input logic lvl, input logic [1:0] cap);
        frz_cmd <= lvl;
        repeat (2) @(posedge pclk);
        #1;
        chk(irq, 32'h0);
        if (cap[0]) begin
            ft[0] = ref_enc.turns;
            fp[0] = ref_enc.position;
        end
        if (cap[1]) begin
            ft[1] = fbk_enc.turns;
            fp[1] = fbk_enc.position;
        end
        @(posedge pclk);
        #1;
        chk(irq, 32'(|cap));
        @(posedge pclk);
    endtask
    task automatic frz_chk(input logic [31:0] fl);
        for (int e = 0; e < 2; e++) begin
            rchk(efmc_pkg::OFF_REF_FTRN + 8'(8 * e), ft[e]);
            rchk(efmc_pkg::OFF_REF_FPOS + 8'(8 * e), fp[e]);
        end
        rchk(efmc_pkg::OFF_FLAGS, fl);
        apb(1'b1, efmc_pkg::OFF_INT_STAT, 32'hF);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // main sequence
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, mrk_cmd, frz_cmd} = '0;
        {n_fail, n_compared} = '0;
        ft = '{32'h0, 32'h0};
        fp = '{32'h0, 32'h0};
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // reset values, read-only snapshots, unmapped places
        for (int a = 0; a < 48; a += 4) rchk(8'(a), 32'h0);
        apb(1'b1, efmc_pkg::OFF_REF_MPOS, 32'hFFFF_FFFF);
        chk(er, 32'h0);
        rchk(efmc_pkg::OFF_REF_MPOS, 32'h0);
        rchk(8'h30, 32'h0);
        chk(er, 32'h1);
        rchk(8'h05, 32'h0);
        chk(er, 32'h1);
        apb(1'b1, efmc_pkg::OFF_INT_MASK, 32'hF);
        rchk(efmc_pkg::OFF_INT_MASK, 32'hF);
        // markers held two cycles: the second overwrites the first
        for (int e = 0; e < 2; e++) begin
            mrk_cmd <= 2'(1 << e);
            @(posedge pclk);
            #1;
            mp = e ? fbk_enc.position : ref_enc.position;
            mt = e ? fbk_enc.turns : ref_enc.turns;
            @(posedge pclk);
            mrk_cmd <= 2'h0;
            @(posedge pclk);
            chk(irq, 32'h1);
            rchk(efmc_pkg::OFF_REF_MPOS + 8'(8 * e), mp);
            rchk(efmc_pkg::OFF_REF_MTRN + 8'(8 * e), mt);
            rchk(efmc_pkg::OFF_FLAGS, 32'h4 << e);
            apb(1'b1, efmc_pkg::OFF_FLAGS, ~(32'h4 << e));
            rchk(efmc_pkg::OFF_FLAGS, 32'h0);
            apb(1'b1, efmc_pkg::OFF_INT_STAT, 32'hF);
            chk(irq, 32'h0);
        end
        // masked event leaves the line low until unmasked
        apb(1'b1, efmc_pkg::OFF_INT_MASK, 32'h0);
        // both markers, flags read right behind them
        mrk_cmd <= 2'h3;
        @(posedge pclk);
        mrk_cmd <= 2'h0;
        rchk(efmc_pkg::OFF_FLAGS, 32'hC);
        chk(irq, 32'h0);
        rchk(efmc_pkg::OFF_INT_STAT, 32'hC);
        apb(1'b1, efmc_pkg::OFF_INT_MASK, 32'hF);
        chk(irq, 32'h1);
        apb(1'b1, efmc_pkg::OFF_INT_STAT, 32'hF);
        apb(1'b1, efmc_pkg::OFF_FLAGS, 32'h0);
        // freeze on rising edge, then per-encoder flag gating
        apb(1'b1, efmc_pkg::OFF_CTRL, 32'h1);
        rchk(efmc_pkg::OFF_CTRL, 32'h1);
        frz(1'b1, 2'b11);
        frz_chk(32'h3);
        apb(1'b1, efmc_pkg::OFF_FLAGS, 32'hFFFF_FFFE);
        frz(1'b0, 2'b00);
        frz(1'b1, 2'b01);
        frz_chk(32'h3);
        // falling edge selected
        apb(1'b1, efmc_pkg::OFF_FLAGS, 32'h0);
        apb(1'b1, efmc_pkg::OFF_CTRL, 32'h3);
        frz(1'b0, 2'b11);
        frz_chk(32'h3);
        // capture disabled
        apb(1'b1, efmc_pkg::OFF_FLAGS, 32'h0);
        apb(1'b1, efmc_pkg::OFF_CTRL, 32'h2);
        frz(1'b1, 2'b00);
        frz(1'b0, 2'b00);
        frz_chk(32'h0);
        print_verdict();
    end
endmodule
